// ---- verilog/aic_adc_ctrl.sv ----
// converter input selection, reference selection and conversion sequencing
// assumes an avalon-mm master on ref_clk and an analog core whose result is
// stable before the last conversion period ends
`timescale 1ns/1ps
`default_nettype none
module aic_adc_ctrl
  import aic_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [NUM_PINS-1:0] pin_pullup_req,
  input  wire logic [NUM_PINS-1:0] pin_dir_out_req,
  input  wire logic [11:0]         core_result,
  output logic      [NUM_PINS-1:0] pin_pullup_on,
  output logic      [NUM_PINS-1:0] pin_digital_en,
  output logic      [NUM_PINS-1:0] pin_drive_en,
  output logic      [NUM_PINS-1:0] analog_inputs_sel,
  output logic      [3:0]          int_source_sel,
  output logic                     ref_regulator_on,
  output logic                     ref_supply_on,
  output logic                     core_power_on,
  output logic                     core_sample,
  output logic                     core_conv_tick,
  output logic                     conv_irq
);
  aic_div_if dv ();

  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        start_ff;
  logic        power_ff;
  logic        align_ff;
  logic [3:0]  ext_ch_ff;
  logic [2:0]  src_ff;
  logic [1:0]  ref_ff;
  logic [2:0]  div_ff;
  logic [NUM_PINS-1:0] pin_func_ff;
  logic        irq_en_ff;
  logic        irq_flag_ff;
  logic        start_fall_ff;
  logic        busy_ff;
  aic_state_e  state_ff;
  logic [3:0]  phase_cnt_ff;
  logic        done_ff;
  logic [11:0] result_ff;
  logic [11:0] core_s1_ff;
  logic [11:0] core_s2_ff;
  logic [NUM_PINS-1:0] pullup_ff;
  logic [NUM_PINS-1:0] digital_ff;
  logic [NUM_PINS-1:0] drive_ff;
  logic [NUM_PINS-1:0] ain_ff;
  logic [3:0]  int_sel_ff;
  logic        ref_reg_ff;
  logic        ref_sup_ff;
  logic        pwr_out_ff;
  logic        sample_ff;
  logic        tick_out_ff;
  logic        irq_out_ff;
  logic        wr_go;
  logic        rd_cap;
  logic        done_now;
  logic        tick;

  function automatic logic is_ext_src(input logic [2:0] s);
    return (s == 3'h0) || (s >= 3'h5);
  endfunction

  function automatic logic [7:0] res_hi(input logic [11:0] r, input logic a);
    return a ? {4'h0, r[11:8]} : r[11:4];
  endfunction

  function automatic logic [7:0] res_lo(input logic [11:0] r, input logic a);
    return a ? r[7:0] : {r[3:0], 4'h0};
  endfunction

  // a request waits one cycle so read data always come from a flop
  assign rd_cap = avs_read && wait_ff;
  assign wr_go  = avs_write && !wait_ff;
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_cap) begin
      unique case (avs_address)
        OFS_CTRL_A: rdata_ff <= {24'h0, start_ff, busy_ff, power_ff, align_ff, ext_ch_ff};
        OFS_CTRL_B: rdata_ff <= {24'h0, src_ff, ref_ff, div_ff};
        OFS_RES_HI: rdata_ff <= {24'h0, res_hi(result_ff, align_ff)};
        OFS_RES_LO: rdata_ff <= {24'h0, res_lo(result_ff, align_ff)};
        OFS_PINFN:  rdata_ff <= {27'h0, pin_func_ff};
        OFS_IRQ:    rdata_ff <= {30'h0, irq_en_ff, irq_flag_ff};
        default:    rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // control registers; the start bit's falling write is the trigger
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_ff      <= RST_CTRL_A[CA_START];
      power_ff      <= RST_CTRL_A[CA_POWER];
      align_ff      <= RST_CTRL_A[CA_ALIGN];
      ext_ch_ff     <= RST_CTRL_A[3:0];
      src_ff        <= RST_CTRL_B[7:5];
      ref_ff        <= RST_CTRL_B[4:3];
      div_ff        <= RST_CTRL_B[2:0];
      pin_func_ff   <= RST_PINFN;
      irq_en_ff     <= 1'b0;
      start_fall_ff <= 1'b0;
    end else begin
      start_fall_ff <= 1'b0;
      if (wr_go && avs_byteenable[0]) begin
        unique case (avs_address)
          OFS_CTRL_A: begin
            start_fall_ff <= start_ff && !avs_writedata[CA_START];
            start_ff      <= avs_writedata[CA_START];
            power_ff      <= avs_writedata[CA_POWER];
            align_ff      <= avs_writedata[CA_ALIGN];
            ext_ch_ff     <= avs_writedata[3:0];
          end
          OFS_CTRL_B: begin
            src_ff <= avs_writedata[CB_SRC_LSB +: 3];
            ref_ff <= avs_writedata[CB_REF_LSB +: 2];
            div_ff <= avs_writedata[2:0];
          end
          OFS_PINFN: pin_func_ff <= avs_writedata[NUM_PINS-1:0];
          OFS_IRQ:   irq_en_ff   <= avs_writedata[IR_EN];
          default: ;
        endcase
      end
    end
  end

  // completion sets the flag; a write of one clears it, but a set in the same cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flag_ff <= 1'b0;
    end else if (done_now) begin
      irq_flag_ff <= 1'b1;
    end else if (wr_go && avs_byteenable[0] && avs_address == OFS_IRQ
                 && avs_writedata[IR_FLAG]) begin
      irq_flag_ff <= 1'b0;
    end
  end

  // divider only runs during a conversion so every conversion starts on a full period
  assign dv.div_code = div_ff;
  // stopped on the completing edge, else a divide-by-one would emit a seventeenth tick
  assign dv.run      = busy_ff && power_ff && !done_now;
  assign tick        = dv.tick;

  aic_clk_div u_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .dv      (dv)
  );

  assign done_now = (state_ff == ST_CONVERT) && tick && (phase_cnt_ff == CONVERT_TICKS - 4'h1)
                    && power_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= ST_IDLE;
      phase_cnt_ff <= 4'h0;
      busy_ff      <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= done_now;
      if (!power_ff) begin
        // power loss abandons the conversion and leaves the results alone
        state_ff     <= ST_IDLE;
        phase_cnt_ff <= 4'h0;
        busy_ff      <= 1'b0;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
            if (start_fall_ff) begin
              state_ff     <= ST_SAMPLE;
              phase_cnt_ff <= 4'h0;
              busy_ff      <= 1'b1;
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (phase_cnt_ff == SAMPLE_TICKS - 4'h1) begin
                state_ff     <= ST_CONVERT;
                phase_cnt_ff <= 4'h0;
              end else begin
                phase_cnt_ff <= phase_cnt_ff + 4'h1;
              end
            end
          end
          ST_CONVERT: begin
            // a start seen while busy falls through unused here
            if (done_now) begin
              state_ff     <= ST_IDLE;
              phase_cnt_ff <= 4'h0;
              busy_ff      <= 1'b0;
            end else if (tick) begin
              phase_cnt_ff <= phase_cnt_ff + 4'h1;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
          end
        endcase
      end
    end
  end

  // the core's word is multi-bit; it is safe only because it is settled long before done
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_s1_ff <= RST_RESULT;
      core_s2_ff <= RST_RESULT;
    end else begin
      core_s1_ff <= core_result;
      core_s2_ff <= core_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= RST_RESULT;
    end else if (done_now) begin
      result_ff <= core_s2_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pullup_ff[gi]  <= 1'b0;
          digital_ff[gi] <= 1'b1;
          drive_ff[gi]   <= 1'b0;
          ain_ff[gi]     <= 1'b0;
        end else begin
          pullup_ff[gi]  <= pin_pullup_req[gi] && !pin_func_ff[gi];
          digital_ff[gi] <= !pin_func_ff[gi];
          drive_ff[gi]   <= pin_dir_out_req[gi] && !pin_func_ff[gi];
          ain_ff[gi]     <= is_ext_src(src_ff) && (ext_ch_ff == 4'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_sel_ff <= 4'h0;
      ref_reg_ff <= 1'b1;
      ref_sup_ff <= 1'b0;
    end else begin
      int_sel_ff <= 4'h0;
      unique case (src_ff)
        3'h1:    int_sel_ff <= 4'h1;
        3'h2:    int_sel_ff <= 4'h2;
        3'h3:    int_sel_ff <= 4'h4;
        3'h4:    int_sel_ff <= 4'h8;
        default: int_sel_ff <= 4'h0;
      endcase
      ref_sup_ff <= (ref_ff == 2'b01);
      ref_reg_ff <= (ref_ff != 2'b01);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_out_ff  <= 1'b0;
      sample_ff   <= 1'b0;
      tick_out_ff <= 1'b0;
      irq_out_ff  <= 1'b0;
    end else begin
      pwr_out_ff  <= power_ff;
      sample_ff   <= (state_ff == ST_SAMPLE);
      tick_out_ff <= tick;
      irq_out_ff  <= irq_flag_ff && irq_en_ff;
    end
  end

  assign pin_pullup_on     = pullup_ff;
  assign pin_digital_en    = digital_ff;
  assign pin_drive_en      = drive_ff;
  assign analog_inputs_sel = ain_ff;
  assign int_source_sel    = int_sel_ff;
  assign ref_regulator_on  = ref_reg_ff;
  assign ref_supply_on     = ref_sup_ff;
  assign core_power_on     = pwr_out_ff;
  assign core_sample       = sample_ff;
  assign core_conv_tick    = tick_out_ff;
  assign conv_irq          = irq_out_ff;

  // helper: conversion clock periods seen during the current conversion
  logic [4:0] tick_total_ff;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_total_ff <= 5'h00;
    end else if (!busy_ff) begin
      tick_total_ff <= 5'h00;
    end else if (tick) begin
      tick_total_ff <= tick_total_ff + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_ref_ldo;
    (ref_ff != 2'b01) |=> (ref_regulator_on && !ref_supply_on);
  endproperty
  a_ref_ldo: assert property (p_ref_ldo) else $error("regulator reference not selected");

  property p_ref_sup;
    (ref_ff == 2'b01) |=> (ref_supply_on && !ref_regulator_on);
  endproperty
  a_ref_sup: assert property (p_ref_sup) else $error("supply reference not selected");

  property p_pin_iso;
    ##1 (($past(pin_func_ff) & (pin_digital_en | pin_pullup_on | pin_drive_en)) == 5'h00);
  endproperty
  a_pin_iso: assert property (p_pin_iso) else $error("analog pin kept a digital function");

  property p_dir_ovr;
    arst_n |=> (pin_drive_en == ($past(pin_dir_out_req) & ~$past(pin_func_ff)));
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("direction not overridden");

  property p_ext_ch;
    // the release edge is skipped: outputs still hold reset values there
    (arst_n && is_ext_src(src_ff) && ext_ch_ff <= EXT_CH_MAX)
      |=> (analog_inputs_sel == 5'(1 << $past(ext_ch_ff)));
  endproperty
  a_ext_ch: assert property (p_ext_ch) else $error("wrong external pin routed");

  property p_int_src;
    (!is_ext_src(src_ff) || ext_ch_ff > EXT_CH_MAX) |=> (analog_inputs_sel == 5'h00);
  endproperty
  a_int_src: assert property (p_int_src) else $error("pin routed while floating or internal");

  property p_busy_set;
    (start_fall_ff && !busy_ff && power_ff) |=> busy_ff [*2];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised after start");

  property p_len;
    done_now |-> (tick_total_ff == 5'd15);
  endproperty
  a_len: assert property (p_len) else $error("conversion not sixteen periods");

  property p_done;
    done_now |=> (!busy_ff && irq_flag_ff && result_ff == $past(core_s2_ff));
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");

  property p_off_hold;
    // two cycles off, so a tick launched just before the drop has drained
    (!power_ff && !$past(power_ff))
      |=> ($stable(result_ff) && !core_conv_tick && !core_power_on);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("converter active while disabled");

  property p_ignore;
    (busy_ff && start_fall_ff && state_ff == ST_SAMPLE) |=> (state_ff != ST_IDLE);
  endproperty
  a_ignore: assert property (p_ignore) else $error("start while busy disturbed conversion");

  c_done:   cover property (done_now && irq_en_ff);
  c_ignore: cover property (busy_ff && start_fall_ff);
  c_abort:  cover property (busy_ff && !power_ff);
endmodule
`default_nettype wire

// ---- shared/aic_pkg.sv ----
// constants, field layout and types of the converter input and conversion control
// assumes one 250 MHz clock and a 32-bit avalon-mm register port
package aic_pkg;
  localparam int unsigned NUM_PINS = 5;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h04;
  localparam logic [4:0] OFS_RES_HI = 5'h08;
  localparam logic [4:0] OFS_RES_LO = 5'h0c;
  localparam logic [4:0] OFS_PINFN  = 5'h10;
  localparam logic [4:0] OFS_IRQ    = 5'h14;

  // converter_control_a fields
  localparam int unsigned CA_START = 7;
  localparam int unsigned CA_BUSY  = 6;
  localparam int unsigned CA_POWER = 5;
  localparam int unsigned CA_ALIGN = 4;
  // converter_control_b fields
  localparam int unsigned CB_SRC_LSB = 5;
  localparam int unsigned CB_REF_LSB = 3;
  // irq register fields
  localparam int unsigned IR_FLAG = 0;
  localparam int unsigned IR_EN   = 1;

  // reset values
  localparam logic [7:0]  RST_CTRL_A = 8'h00;
  localparam logic [7:0]  RST_CTRL_B = 8'h00;
  localparam logic [4:0]  RST_PINFN  = 5'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;

  // conversion clock periods per phase
  localparam logic [3:0] SAMPLE_TICKS  = 4'h4;
  localparam logic [3:0] CONVERT_TICKS = 4'hc;

  localparam logic [3:0] EXT_CH_MAX = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } aic_state_e;
endpackage

// ---- shared/aic_div_if.sv ----
// carrier between the sequencer and the conversion clock divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface aic_div_if;
  logic [2:0] div_code;
  logic       run;
  logic       tick;
  modport ctl (output div_code, output run, input tick);
  modport div (input div_code, input run, output tick);
endinterface
`default_nettype wire

// ---- verilog/aic_clk_div.sv ----
// conversion clock divider: one tick per conversion clock period
// assumes the controller holds run low whenever no conversion is active
`timescale 1ns/1ps
`default_nettype none
module aic_clk_div
  import aic_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  aic_div_if.div    dv
);
  logic [6:0] cnt_ff;
  logic       tick_ff;
  logic [6:0] limit;

  // divisor is 2^code, so the terminal count is 2^code - 1
  assign limit = 7'((8'h01 << dv.div_code) - 8'h01);
  assign dv.tick = tick_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (!dv.run) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff == limit) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_div_period;
    (dv.run && !tick_ff && cnt_ff == 7'h00 && dv.div_code == 3'h2) ##1 dv.run [*3]
      |=> tick_ff;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divide by four tick late");
endmodule
`default_nettype wire

// ---- test/aic_adc_ctrl_test.sv ----
// self-checking bench for the converter input and conversion control block
// assumes the block's avalon-mm port is the only way in, and drives pins and core result itself
`timescale 1ns/1ps
`default_nettype none
module aic_adc_ctrl_test;
  import aic_pkg::*;

  logic                ref_clk;
  logic                arst_n;
  logic [4:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [NUM_PINS-1:0] pin_pullup_req;
  logic [NUM_PINS-1:0] pin_dir_out_req;
  logic [11:0]         core_result;
  logic [NUM_PINS-1:0] pin_pullup_on;
  logic [NUM_PINS-1:0] pin_digital_en;
  logic [NUM_PINS-1:0] pin_drive_en;
  logic [NUM_PINS-1:0] analog_inputs_sel;
  logic [3:0]          int_source_sel;
  logic                ref_regulator_on;
  logic                ref_supply_on;
  logic                core_power_on;
  logic                core_sample;
  logic                core_conv_tick;
  logic                conv_irq;
  int                  bad_count;
  int                  checked;
  int                  cyc;
  int                  ticks;
  int                  samp_ticks;
  int                  last_tick;
  int                  tick_gap;
  logic [7:0]          q;
  logic [7:0]          hi_exp;
  logic [7:0]          lo_exp;

  aic_adc_ctrl i_aic_adc_ctrl (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .pin_pullup_req    (pin_pullup_req),
    .pin_dir_out_req   (pin_dir_out_req),
    .core_result       (core_result),
    .pin_pullup_on     (pin_pullup_on),
    .pin_digital_en    (pin_digital_en),
    .pin_drive_en      (pin_drive_en),
    .analog_inputs_sel (analog_inputs_sel),
    .int_source_sel    (int_source_sel),
    .ref_regulator_on  (ref_regulator_on),
    .ref_supply_on     (ref_supply_on),
    .core_power_on     (core_power_on),
    .core_sample       (core_sample),
    .core_conv_tick    (core_conv_tick),
    .conv_irq          (conv_irq)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hung handshake or poll lands here instead of running forever
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end

  // tick spacing and sample-phase length are measured on the pins, not the registers
  always @(posedge ref_clk) begin
    if (core_conv_tick === 1'b1) begin
      tick_gap <= cyc - last_tick;
      last_tick <= cyc;
      ticks <= ticks + 1;
      if (core_sample === 1'b1) samp_ticks <= samp_ticks + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low, data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge ref_clk);
    avs_address   <= adr;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h000000, wd};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(1'b1, adr, wd, dummy);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    do bus(1'b0, OFS_CTRL_A, 8'h00, q); while (q[CA_BUSY] !== 1'b0);
  endtask

  task automatic conv(input logic [2:0] div, input logic al, input logic [11:0] res);
    int t0;
    int s0;
    wr(OFS_CTRL_B, {5'h00, div});
    wr(OFS_IRQ, {6'h00, div[1], 1'b1});
    core_result <= res;
    wr(OFS_CTRL_A, {3'b101, al, 4'h0});
    settle();
    t0 = ticks;
    s0 = samp_ticks;
    wr(OFS_CTRL_A, {3'b001, al, 4'h0});
    bus(1'b0, OFS_CTRL_A, 8'h00, q);
    check(q[CA_BUSY], 1'b1);
    if (div == 3'h7) begin
      wr(OFS_CTRL_A, {3'b101, al, 4'h0});
      wr(OFS_CTRL_A, {3'b001, al, 4'h0});
    end
    wait_idle();
    check(ticks - t0, 16);
    check(samp_ticks - s0, 4);
    check(tick_gap, 1 << div);
    hi_exp = al ? {4'h0, res[11:8]} : res[11:4];
    lo_exp = al ? res[7:0] : {res[3:0], 4'h0};
    bus(1'b0, OFS_RES_HI, 8'h00, q);
    check(q, hi_exp);
    bus(1'b0, OFS_RES_LO, 8'h00, q);
    check(q, lo_exp);
    bus(1'b0, OFS_IRQ, 8'h00, q);
    check(q[IR_FLAG], 1'b1);
    check(conv_irq, div[1]);
  endtask

  initial begin
    arst_n <= 1'b0;
    avs_address <= 5'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h00000000;
    avs_byteenable <= 4'hf;
    pin_pullup_req <= 5'h1f;
    pin_dir_out_req <= 5'h1f;
    core_result <= 12'h000;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    check(pin_digital_en, 5'h1f);
    check(ref_regulator_on, 1'b1);
    check(core_power_on, 1'b0);
    bus(1'b0, OFS_CTRL_A, 8'h00, q);
    check(q, RST_CTRL_A);
    bus(1'b0, OFS_CTRL_B, 8'h00, q);
    check(q, RST_CTRL_B);
    bus(1'b0, 5'h18, 8'h00, q);
    check(q, 8'h00);
    // busy is read-only, so writing it must not read back
    wr(OFS_CTRL_A, 8'h40);
    bus(1'b0, OFS_CTRL_A, 8'h00, q);
    check(q, 8'h00);
    // analog pins lose pull-up, driver and digital path; others keep them
    wr(OFS_PINFN, 8'h15);
    settle();
    check(pin_pullup_on, 5'h0a);
    check(pin_digital_en, 5'h0a);
    check(pin_drive_en, 5'h0a);
    wr(OFS_PINFN, 8'h00);
    settle();
    check(pin_pullup_on & pin_digital_en & pin_drive_en, 5'h1f);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CTRL_B, {3'b000, r[1:0], 3'b000});
      settle();
      check(ref_regulator_on, r != 1);
      check(ref_supply_on, r == 1);
    end
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 7; c++) begin
        logic [3:0] ch;
        logic       ext;
        ch = (c == 6) ? 4'hf : 4'(c);
        ext = (s == 0) || (s >= 5);
        wr(OFS_CTRL_A, {4'h0, ch});
        wr(OFS_CTRL_B, {3'(s), 5'h00});
        settle();
        check(analog_inputs_sel, (ext && ch <= EXT_CH_MAX) ? 5'h01 << ch : 5'h00);
        check(int_source_sel, (s >= 1 && s <= 4) ? 4'h1 << (s - 1) : 4'h0);
      end
    end
    for (int d = 0; d < 8; d++) begin
      conv(3'(d), d[0], 12'h5a3 ^ 12'(d * 273));
    end
    check(core_power_on, 1'b1);
    // power drop: start ignored, mid-run abort leaves results and flag alone
    wr(OFS_IRQ, 8'h01);
    wr(OFS_CTRL_A, 8'h10);
    settle();
    check(core_power_on, 1'b0);
    wr(OFS_CTRL_A, 8'h90);
    wr(OFS_CTRL_A, 8'h10);
    bus(1'b0, OFS_CTRL_A, 8'h00, q);
    check(q[CA_BUSY], 1'b0);
    wr(OFS_CTRL_A, 8'hb0);
    core_result <= 12'h123;
    wr(OFS_CTRL_A, 8'h30);
    repeat (200) @(posedge ref_clk);
    wr(OFS_CTRL_A, 8'h10);
    wait_idle();
    bus(1'b0, OFS_RES_HI, 8'h00, q);
    check(q, hi_exp);
    bus(1'b0, OFS_RES_LO, 8'h00, q);
    check(q, lo_exp);
    bus(1'b0, OFS_IRQ, 8'h00, q);
    check(q[IR_FLAG], 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
